//--- isrf_status_flags.sv
`timescale 1ns/1ps
`include "isrf_defs.svh"

// Summary of operation
// - the receive-ready flag sets when a byte moves from rx_shift_reg into rx_data_reg.
// - the receive-ready flag clears on module_run_bit low or on processor reset.
// - the register-access-ready flag sits at status bit 2 and only acts in master mode.
// - the register-access-ready flag sets once address, data and command are consumed.
// - the register-access-ready flag clears when the controller starts using the registers.
// - writing 1 to bit 2 clears the register-access-ready flag, writing 0 leaves it.
// - the register-access-ready flag is both a pollable bit and an interrupt request source.
// - reading rx_data_reg clears the receive-ready flag.
// - writing 1 to status bit 3 clears the receive-ready flag.

module isrf_status_flags #(
  // widths
  parameter int DATA_W = `ISRF_DATA_W,
  parameter int STAT_W = `ISRF_STAT_W
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // mode control
  input  wire logic              module_run_bit,
  input  wire logic              master_mode,
  // serial engine events
  input  wire logic              rx_xfer_done,
  input  wire logic [DATA_W-1:0] rx_shift_reg,
  input  wire logic              regs_consumed,
  input  wire logic              regs_start_use,
  // cpu side
  input  wire logic              rx_data_rd,
  input  wire logic              stat_wr,
  input  wire logic [STAT_W-1:0] stat_wdata,
  // results
  output logic [DATA_W-1:0]      rx_data_reg,
  output logic                   receive_ready_flag,
  output logic                   regs_access_ready_flag,
  output logic                   access_irq_req
);

  // ***********************************************
  // elaboration checks
  // ***********************************************
  // both clear bits must land inside the status write word
  if (STAT_W <= `ISRF_RRDY_BIT || STAT_W <= `ISRF_ACC_BIT) begin : g_bad_stat_w
    $error("stat_wdata too narrow for the clear bits");
  end
  if (`ISRF_RRDY_BIT == `ISRF_ACC_BIT) begin : g_bad_bit_pos
    $error("the two clear bits must differ");
  end
  if (DATA_W < 1) begin : g_bad_data_w
    $error("rx data width must be at least one bit");
  end
  if (`ISRF_FLAG_RST != 1'h0) begin : g_bad_flag_rst
    $error("flags must reset to zero");
  end

  // ***********************************************
  // declarations
  // ***********************************************
  // flag slots
  localparam int NUM_FLAGS = 2;
  localparam int RX_IDX    = 0;
  localparam int ACC_IDX   = 1;

  // event decode
  logic                     ctl_reset;
  logic                     rx_rd_clr;
  logic                     rx_wr_clr;
  logic                     acc_wr_clr;

  // flag cells
  logic [NUM_FLAGS-1:0]     flag_hold;
  logic [NUM_FLAGS-1:0]     flag_set;
  logic [NUM_FLAGS-1:0]     flag_clr;
  logic [NUM_FLAGS-1:0]     flag_bits;

  // command tracking
  isrf_pkg::isrf_state_type cmd_state_ff;
  isrf_pkg::isrf_state_type nxt_cmd_state;

  // receive data
  logic [DATA_W-1:0]        rx_data_ff;
  logic [DATA_W-1:0]        nxt_rx_data;

  // interrupt request
  logic                     acc_irq_ff;
  logic                     nxt_acc_irq;

  // ***********************************************
  // event decode
  // ***********************************************
  // each flag: hold wins, then set, then clear
  // status writes clear only where a 1 is written
  always_comb begin
    ctl_reset          = !module_run_bit;
    rx_rd_clr          = rx_data_rd;
    rx_wr_clr          = stat_wr && stat_wdata[`ISRF_RRDY_BIT];
    acc_wr_clr         = stat_wr && stat_wdata[`ISRF_ACC_BIT];
    // receive-ready events
    flag_hold[RX_IDX]  = ctl_reset;
    flag_set[RX_IDX]   = rx_xfer_done;
    flag_clr[RX_IDX]   = rx_rd_clr || rx_wr_clr;
    // register-access-ready events, only meaningful as bus master
    flag_hold[ACC_IDX] = ctl_reset || !master_mode;
    flag_set[ACC_IDX]  = regs_consumed && (cmd_state_ff == isrf_pkg::ISRF_BUSY);
    flag_clr[ACC_IDX]  = regs_start_use || acc_wr_clr;
  end

  // ***********************************************
  // command tracking
  // ***********************************************
  // consumption only counts after a start; avoids a stray ready at idle
  // a second start while busy is not queued
  always_comb begin
    nxt_cmd_state = cmd_state_ff;
    case (cmd_state_ff)
      isrf_pkg::ISRF_IDLE: begin
        if (regs_start_use) begin
          nxt_cmd_state = isrf_pkg::ISRF_BUSY;
        end
      end
      isrf_pkg::ISRF_BUSY: begin
        if (regs_consumed) begin
          nxt_cmd_state = isrf_pkg::ISRF_DONE;
        end
      end
      isrf_pkg::ISRF_DONE: begin
        if (regs_start_use) begin
          nxt_cmd_state = isrf_pkg::ISRF_BUSY;
        end else begin
          nxt_cmd_state = isrf_pkg::ISRF_IDLE;
        end
      end
      default: begin
        nxt_cmd_state = isrf_pkg::ISRF_IDLE;
      end
    endcase
    if (flag_hold[ACC_IDX]) begin
      nxt_cmd_state = isrf_pkg::ISRF_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_state_ff <= isrf_pkg::ISRF_IDLE;
    end else begin
      cmd_state_ff <= nxt_cmd_state;
    end
  end

  // ***********************************************
  // receive data register
  // ***********************************************
  // loads even while module_run_bit is low; only nrst clears it
  always_comb begin
    nxt_rx_data = rx_data_ff;
    if (rx_xfer_done) begin
      nxt_rx_data = rx_shift_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_data_ff <= {DATA_W{1'b0}};
    end else begin
      rx_data_ff <= nxt_rx_data;
    end
  end

  // ***********************************************
  // flags
  // ***********************************************
  // one cell per flag; both share the hold > set > clear order
  for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
    isrf_flag_cell isrf_flag_cell_i (
      .clk      (clk),
      .nrst     (nrst),
      .hold_clr (flag_hold[i]),
      .set_evt  (flag_set[i]),
      .clr_evt  (flag_clr[i]),
      .flag_ff  (flag_bits[i])
    );
  end

  // ***********************************************
  // interrupt request
  // ***********************************************
  // irq request mirrors the flag's next value so both rise together
  always_comb begin
    nxt_acc_irq = acc_irq_ff;
    if (flag_clr[ACC_IDX]) begin
      nxt_acc_irq = 1'h0;
    end
    if (flag_set[ACC_IDX]) begin
      nxt_acc_irq = 1'h1;
    end
    if (flag_hold[ACC_IDX]) begin
      nxt_acc_irq = `ISRF_FLAG_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_irq_ff <= `ISRF_FLAG_RST;
    end else begin
      acc_irq_ff <= nxt_acc_irq;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  // every output comes straight from a flop
  assign rx_data_reg            = rx_data_ff;
  assign receive_ready_flag     = flag_bits[RX_IDX];
  assign regs_access_ready_flag = flag_bits[ACC_IDX];
  assign access_irq_req         = acc_irq_ff;

endmodule : isrf_status_flags

//--- isrf_defs.svh
`ifndef ISRF_DEFS_SVH
`define ISRF_DEFS_SVH

// ***********************************************
// status bit positions
// ***********************************************
`define ISRF_ACC_BIT  2
`define ISRF_RRDY_BIT 3

// ***********************************************
// reset values and widths
// ***********************************************
`define ISRF_FLAG_RST 1'h0
`define ISRF_DATA_W   8
`define ISRF_STAT_W   4

`endif

//--- isrf_pkg.sv
package isrf_pkg;

  typedef enum logic [1:0] {
    ISRF_IDLE = 2'h0,
    ISRF_BUSY = 2'h1,
    ISRF_DONE = 2'h3
  } isrf_state_type;

endpackage : isrf_pkg

//--- isrf_flag_cell.sv
`timescale 1ns/1ps
`include "isrf_defs.svh"

module isrf_flag_cell (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // events
  input  wire logic hold_clr,
  input  wire logic set_evt,
  input  wire logic clr_evt,
  // state
  output logic      flag_ff
);

  logic nxt_flag;

  // set wins over clear so no event is lost
  always_comb begin
    nxt_flag = flag_ff;
    if (clr_evt) begin
      nxt_flag = 1'h0;
    end
    if (set_evt) begin
      nxt_flag = 1'h1;
    end
    if (hold_clr) begin
      nxt_flag = `ISRF_FLAG_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      flag_ff <= `ISRF_FLAG_RST;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

endmodule : isrf_flag_cell

//--- isrf_status_flags_chk.sv
`timescale 1ns/1ps
`include "isrf_defs.svh"
module isrf_status_flags_chk (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    nrst,
  // inputs
  input wire logic                    module_run_bit,
  input wire logic                    master_mode,
  input wire logic                    rx_xfer_done,
  input wire logic [`ISRF_DATA_W-1:0] rx_shift_reg,
  input wire logic                    regs_consumed,
  input wire logic                    regs_start_use,
  input wire logic                    rx_data_rd,
  input wire logic                    stat_wr,
  input wire logic [`ISRF_STAT_W-1:0] stat_wdata,
  // outputs
  input wire logic [`ISRF_DATA_W-1:0] rx_data_reg,
  input wire logic                    receive_ready_flag,
  input wire logic                    regs_access_ready_flag,
  input wire logic                    access_irq_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire on = module_run_bit && master_mode;
  wire ar = regs_access_ready_flag;
  wire rr = receive_ready_flag;
  sequence s_start; regs_start_use && !regs_consumed && on; endsequence
  sequence s_done; regs_consumed && !regs_start_use && on; endsequence
  property p_rx_set; rx_xfer_done && module_run_bit |=> rr && rx_data_reg == $past(rx_shift_reg);
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("rx load missed");
  property p_rx_hold; !module_run_bit |=> !rr; endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx flag not held");
  property p_rx_clr; (rx_data_rd || stat_wr && stat_wdata[`ISRF_RRDY_BIT]) && !rx_xfer_done
    |=> !rr;
  endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("rx flag not cleared");
  property p_ar_off; !on |=> !ar; endproperty
  a_ar_off: assert property (p_ar_off) else $error("access flag outside master");
  property p_ar_set; s_start ##1 s_done |=> ar; endproperty
  a_ar_set: assert property (p_ar_set) else $error("access flag not set");
  property p_ar_use; regs_start_use && !regs_consumed |=> !ar; endproperty
  a_ar_use: assert property (p_ar_use) else $error("access flag not cleared on use");
  property p_ar_wr; stat_wr && stat_wdata[`ISRF_ACC_BIT] && !regs_consumed |=> !ar;
  endproperty
  a_ar_wr: assert property (p_ar_wr) else $error("access flag write clear");
  property p_ar_keep; ar && on && stat_wr && !stat_wdata[`ISRF_ACC_BIT] && !regs_start_use
    |=> ar;
  endproperty
  a_ar_keep: assert property (p_ar_keep) else $error("access flag lost on zero write");
  property p_irq; access_irq_req == ar; endproperty
  a_irq: assert property (p_irq) else $error("irq differs from access flag");
endmodule : isrf_status_flags_chk

bind isrf_status_flags isrf_status_flags_chk isrf_status_flags_chk_i (
  .clk                    (clk),
  .nrst                   (nrst),
  .module_run_bit         (module_run_bit),
  .master_mode            (master_mode),
  .rx_xfer_done           (rx_xfer_done),
  .rx_shift_reg           (rx_shift_reg),
  .regs_consumed          (regs_consumed),
  .regs_start_use         (regs_start_use),
  .rx_data_rd             (rx_data_rd),
  .stat_wr                (stat_wr),
  .stat_wdata             (stat_wdata),
  .rx_data_reg            (rx_data_reg),
  .receive_ready_flag     (receive_ready_flag),
  .regs_access_ready_flag (regs_access_ready_flag),
  .access_irq_req         (access_irq_req)
);

//--- tb.sv
`timescale 1ns/1ps
`include "isrf_defs.svh"
module tb;
  logic clk, nrst, run, mm, xfer, cons, start, rd, wr, rr, ar, irq, e_rr, e_ar, pend;
  logic [7:0]  sh, dreg, e_d;
  logic [3:0]  wd;
  logic [31:0] seed = 32'ha121_7169;
  int          num_errors, total_checks, cyc;
  isrf_status_flags isrf_status_flags_i (.clk(clk), .nrst(nrst), .module_run_bit(run),
    .master_mode(mm), .rx_xfer_done(xfer), .rx_shift_reg(sh), .regs_consumed(cons),
    .regs_start_use(start), .rx_data_rd(rd), .stat_wr(wr), .stat_wdata(wd),
    .rx_data_reg(dreg), .receive_ready_flag(rr), .regs_access_ready_flag(ar),
    .access_irq_req(irq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  // set beats read or write clear
  function automatic logic f_rr(input logic q);
    if (!nrst || !run) return 1'h0;
    if (xfer) return 1'h1;
    return q && !rd && !(wr && wd[3]);
  endfunction : f_rr
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // ******************
  // reference model
  // ******************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    e_rr <= f_rr(e_rr);
    e_d <= !nrst ? 8'h00 : xfer ? sh : e_d;
    if (!nrst || !run || !mm) begin
      pend <= 1'h0;
      e_ar <= 1'h0;
    end else if (cons && pend) begin
      pend <= 1'h0;
      e_ar <= 1'h1;
    end else if (start || wr && wd[2]) begin
      pend <= pend || start;
      e_ar <= 1'h0;
    end
    if (cyc > 4000) begin
      num_errors++;
      results;
    end
  end
  always @(negedge clk) if (cyc > 0) begin
    chk({rr, dreg}, {e_rr, e_d});
    chk({7'h00, ar, irq}, {7'h00, e_ar, e_ar});
  end
  initial begin
    {nrst, run, mm, xfer, cons, start, rd, wr, sh, wd} = '0;
    {e_rr, e_ar, pend, e_d, cyc} = '0;
    repeat (3) @(negedge clk);
    {nrst, run, mm, start} = 4'hf;
    @(negedge clk) {start, cons} = 2'h1;
    @(negedge clk) {cons, wr, wd} = 6'h1b;
    @(negedge clk) wd = 4'h4;
    @(negedge clk) wr = 1'h0;
    // random traffic, with rare resets and mode drops
    repeat (3000) begin
      @(negedge clk);
      seed = xs(seed);
      nrst = seed[31:26] != 6'h00;
      run = seed[7:0] != 8'h00;
      mm = seed[15:8] > 8'h04;
      {xfer, sh, cons, rd, wr, wd} = {&seed[17:16], seed[31:24], seed[20], &seed[22:21],
        &seed[25:24], seed[29:26]};
      start = &seed[19:18] && !seed[20];
    end
    results;
  end
endmodule : tb
